// ==== iosrf_framer.sv ====
// file holds the api frame builder for io samples and received rf data
//
// The address map and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
module iosrf_framer (
	input  wire logic               I_MCLK,
	input  wire logic               I_NRST,
	input  wire iosrf_pkg::iosrf_axi_in_t I_AXI,
	output iosrf_pkg::iosrf_axi_out_t     O_AXI,
	input  wire logic               I_SMP_VALID,
	input  wire iosrf_pkg::iosrf_smp_t    I_SMP,
	output logic                    O_SMP_READY,
	input  wire logic               I_PKT_VALID,
	input  wire iosrf_pkg::iosrf_pkt_t    I_PKT,
	output logic                    O_PKT_READY,
	input  wire logic               I_PAY_VALID,
	input  wire logic [7:0]         I_PAY_DATA,
	output logic                    O_PAY_READY,
	output logic [7:0]              O_TX_DATA,
	output logic                    O_TX_VALID,
	input  wire logic               I_TX_READY
);
	import iosrf_pkg::*;

	typedef struct packed {
		iosrf_st_t        st;
		logic             kind;
		logic             turn;
		logic             smp_rdy;
		logic             pkt_rdy;
		logic [LEN_W-1:0] len;
		logic [LEN_W-1:0] plen;
		logic [LEN_W-1:0] rem;
		logic [LEN_W-1:0] idx;
		logic [0:14][7:0] hdr;
		iosrf_var_t       vr;
		logic [7:0]       cks;
		logic [7:0]       tx_data;
		logic             tx_vld;
		logic             api_en;
		logic             out_opt;
		logic [15:0]      n_smp;
		logic [15:0]      n_pkt;
		logic [15:0]      n_drop;
		logic             aw_got;
		logic [7:0]       aw_addr;
		logic             w_got;
		logic [31:0]      w_data;
		logic [3:0]       w_strb;
		iosrf_axi_out_t   axo;
	} iosrf_state_t;

	iosrf_state_t     q;
	iosrf_state_t     n;
	logic [1:0]       rst_sync;
	logic             rst_n;
	logic             load;
	logic             pop;
	logic             fifo_vld;
	logic [7:0]       fifo_data;
	logic             pay_rdy;
	logic [LEN_W-1:0] fix_last;
	logic [LEN_W-1:0] pkt_plen;
	iosrf_var_t       smp_var;

	// ******************************************************
	// functions
	// ******************************************************

	// pack the variable part of a sample frame
	function automatic iosrf_var_t build_var(input iosrf_smp_t s);
		iosrf_var_t v;
		logic [7:0] am;
		v  = '0;
		am = s.amask & AMASK_USED;
		if ((s.dmask & DMASK_USED) != 16'h0000)
		begin
			v.b[0] = s.dsamp[15:8] & s.dmask[15:8] & DMASK_USED[15:8];
			v.b[1] = s.dsamp[7:0] & s.dmask[7:0];
			v.cnt  = 4'h2;
		end
		for (int i = 0; i < 4; i++)
		begin
			if (am[i])
			begin
				v.b[v.cnt]        = s.aval[i][15:8];
				v.b[v.cnt + 4'h1] = s.aval[i][7:0];
				v.cnt             = v.cnt + 4'h2;
			end
		end
		if (am[AMASK_VCC])
		begin
			v.b[v.cnt]        = s.supply[15:8];
			v.b[v.cnt + 4'h1] = s.supply[7:0];
			v.cnt             = v.cnt + 4'h2;
		end
		return v;
	endfunction

	// register read mux
	function automatic logic [31:0] read_reg(input logic [7:0] a, input iosrf_state_t s);
		logic [31:0] d;
		d = 32'h0000_0000;
		unique case ({a[7:2], 2'b00})
			REG_CTRL: d = {30'h0, s.out_opt, s.api_en};
			REG_STAT: d = {30'h0, s.kind, s.st != ST_IDLE};
			REG_SENT: d = {s.n_pkt, s.n_smp};
			REG_DROP: d = {16'h0000, s.n_drop};
			default:  d = 32'h0000_0000;
		endcase
		return d;
	endfunction

	// address decode shared by read and write
	function automatic logic reg_hit(input logic [7:0] a);
		return a[7:4] == 4'h0;
	endfunction

	// ******************************************************
	// reset and payload buffer
	// ******************************************************

	// release the reset through two flops
	always_ff @(posedge I_MCLK or negedge I_NRST)
	begin
		if (!I_NRST)
			rst_sync <= 2'b00;
		else
			rst_sync <= {rst_sync[0], 1'b1};
	end
	assign rst_n = rst_sync[1];

	iosrf_fifo #(
		.W (FIFO_W),
		.D (FIFO_DEPTH)
	) u_fifo (
		.i_clk       (I_MCLK),
		.i_rst_n     (rst_n),
		.i_in_valid  (I_PAY_VALID),
		.i_in_data   (I_PAY_DATA),
		.o_in_ready  (pay_rdy),
		.o_out_valid (fifo_vld),
		.o_out_data  (fifo_data),
		.i_out_ready (pop)
	);

	// ******************************************************
	// frame builder and register slave
	// ******************************************************

	// helpers for the sequencer
	assign load     = !q.tx_vld || I_TX_READY;
	assign fix_last = q.kind ? PKT_FIX_LEN - 11'h1 : SMP_FIX_LEN - 11'h1;
	assign pkt_plen = (I_PKT.len > MAX_PAY) ? MAX_PAY : I_PKT.len;
	assign smp_var  = build_var(I_SMP);

	// next state
	always_comb
	begin
		n   = q;
		pop = 1'b0;
		if (load)
			n.tx_vld = 1'b0;
		unique case (q.st)
			ST_IDLE:
			begin
				n.turn = !q.turn;
				if (q.smp_rdy && I_SMP_VALID)
				begin
					if (q.api_en)
					begin
						n.kind  = 1'b0;
						n.hdr   = {TYPE_SMP, 32'h0000_0000, I_SMP.ip, I_SMP.rssi, RX_OPTS, SMP_COUNT,
							I_SMP.dmask & DMASK_USED, I_SMP.amask & AMASK_USED};
						n.vr    = smp_var;
						n.len   = SMP_FIX_LEN + {7'h00, smp_var.cnt};
						n.plen  = '0;
						n.rem   = '0;
						n.st    = ST_SOF;
						n.n_smp = q.n_smp + 16'h0001;
					end
					else
						n.n_drop = q.n_drop + 16'h0001;
				end
				else if (q.pkt_rdy && I_PKT_VALID)
				begin
					if (q.api_en && !q.out_opt)
					begin
						n.kind  = 1'b1;
						n.hdr   = {TYPE_PKT, 32'h0000_0000, I_PKT.ip, RSV_HI, RSV_LO,
							6'h00, I_PKT.bcast, 1'b0, 24'h000000};
						n.vr    = '0;
						n.plen  = pkt_plen;
						n.rem   = I_PKT.len - pkt_plen;
						n.len   = PKT_FIX_LEN + pkt_plen;
						n.st    = ST_SOF;
						n.n_pkt = q.n_pkt + 16'h0001;
					end
					else
					begin
						n.rem    = I_PKT.len;
						n.st     = (I_PKT.len != '0) ? ST_DROP : ST_IDLE;
						n.n_drop = q.n_drop + 16'h0001;
					end
				end
			end
			ST_SOF:
			begin
				if (load)
				begin
					n.tx_data = DELIM;
					n.tx_vld  = 1'b1;
					n.st      = ST_LENH;
				end
			end
			ST_LENH:
			begin
				if (load)
				begin
					n.tx_data = {5'h00, q.len[10:8]};
					n.tx_vld  = 1'b1;
					n.st      = ST_LENL;
				end
			end
			ST_LENL:
			begin
				if (load)
				begin
					n.tx_data = q.len[7:0];
					n.tx_vld  = 1'b1;
					n.idx     = '0;
					n.cks     = 8'h00;
					n.st      = ST_FIX;
				end
			end
			ST_FIX:
			begin
				if (load)
				begin
					n.tx_data = q.hdr[q.idx[3:0]];
					n.tx_vld  = 1'b1;
					n.cks     = q.cks + q.hdr[q.idx[3:0]];
					n.idx     = q.idx + 11'h1;
					if (q.idx == fix_last)
					begin
						n.idx = '0;
						if (q.kind)
							n.st = (q.plen != '0) ? ST_PAY : ST_CSUM;
						else
							n.st = (q.vr.cnt != 4'h0) ? ST_VAR : ST_CSUM;
					end
				end
			end
			ST_VAR:
			begin
				if (load)
				begin
					n.tx_data = q.vr.b[q.idx[3:0]];
					n.tx_vld  = 1'b1;
					n.cks     = q.cks + q.vr.b[q.idx[3:0]];
					n.idx     = q.idx + 11'h1;
					if (q.idx[3:0] == q.vr.cnt - 4'h1)
						n.st = ST_CSUM;
				end
			end
			ST_PAY:
			begin
				if (load && fifo_vld)
				begin
					pop       = 1'b1;
					n.tx_data = fifo_data;
					n.tx_vld  = 1'b1;
					n.cks     = q.cks + fifo_data;
					n.idx     = q.idx + 11'h1;
					if (q.idx == q.plen - 11'h1)
						n.st = ST_CSUM;
				end
			end
			ST_CSUM:
			begin
				if (load)
				begin
					n.tx_data = CSUM_BASE - q.cks;
					n.tx_vld  = 1'b1;
					n.st      = (q.rem != '0) ? ST_DROP : ST_IDLE;
				end
			end
			ST_DROP:
			begin
				if (fifo_vld)
				begin
					pop   = 1'b1; // discard bytes past the limit or not forwarded
					n.rem = q.rem - 11'h1;
					if (q.rem == 11'h1)
						n.st = ST_IDLE;
				end
			end
		endcase
		n.smp_rdy = (n.st == ST_IDLE) && !n.turn;
		n.pkt_rdy = (n.st == ST_IDLE) && n.turn;

		// write channel: address and data taken in either order
		if (q.axo.bvalid && I_AXI.bready)
			n.axo.bvalid = 1'b0;
		if (I_AXI.awvalid && q.axo.awready)
		begin
			n.aw_got  = 1'b1;
			n.aw_addr = I_AXI.awaddr;
		end
		if (I_AXI.wvalid && q.axo.wready)
		begin
			n.w_got  = 1'b1;
			n.w_data = I_AXI.wdata;
			n.w_strb = I_AXI.wstrb;
		end
		if (n.aw_got && n.w_got && !n.axo.bvalid)
		begin
			n.aw_got     = 1'b0;
			n.w_got      = 1'b0;
			n.axo.bvalid = 1'b1;
			n.axo.bresp  = reg_hit(n.aw_addr) ? RESP_OKAY : RESP_SLVERR;
			if ({n.aw_addr[7:2], 2'b00} == REG_CTRL && n.w_strb[0])
			begin
				n.api_en  = n.w_data[CTRL_API];
				n.out_opt = n.w_data[CTRL_OPT];
			end
		end
		n.axo.awready = !n.aw_got && !n.axo.bvalid;
		n.axo.wready  = !n.w_got && !n.axo.bvalid;

		// read channel: one outstanding read
		if (q.axo.rvalid && I_AXI.rready)
			n.axo.rvalid = 1'b0;
		if (I_AXI.arvalid && q.axo.arready)
		begin
			n.axo.rvalid = 1'b1;
			n.axo.rdata  = read_reg(I_AXI.araddr, q);
			n.axo.rresp  = reg_hit(I_AXI.araddr) ? RESP_OKAY : RESP_SLVERR;
		end
		n.axo.arready = !n.axo.rvalid;
	end

	// state register
	always_ff @(posedge I_MCLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			q        <= '0;
			q.api_en <= API_RST;
		end
		else
			q <= n;
	end

	// outputs straight from flops
	assign O_AXI       = q.axo;
	assign O_SMP_READY = q.smp_rdy;
	assign O_PKT_READY = q.pkt_rdy;
	assign O_PAY_READY = pay_rdy;
	assign O_TX_DATA   = q.tx_data;
	assign O_TX_VALID  = q.tx_vld;

	// ******************************************************
	// assertions
	// ******************************************************

	default clocking cb @(posedge I_MCLK); endclocking
	default disable iff (!rst_n);

	a_smp_type: assert property ((q.st == ST_FIX && q.idx == '0 && !q.kind && load) |=>
		(O_TX_VALID && O_TX_DATA == TYPE_SMP)) else $error("sample type byte wrong");
	a_api_gate: assert property ((O_SMP_READY && I_SMP_VALID && !q.api_en) |=>
		(q.st != ST_SOF) [*2]) else $error("sample sent outside api mode");
	a_addr_upper: assert property ((q.st == ST_FIX && load && q.idx >= 11'h1 && q.idx <= 11'h4) |=>
		(O_TX_DATA == 8'h00)) else $error("upper address byte not zero");
	a_count_one: assert property ((q.st == ST_FIX && !q.kind && q.idx == 11'hB && load) |=>
		(O_TX_DATA == SMP_COUNT)) else $error("sample count not one");
	a_dig_zero: assert property ((q.st == ST_SOF && !q.kind && q.vr.cnt != 4'h0 &&
		{q.hdr[12], q.hdr[13]} != 16'h0) |-> (({q.vr.b[0], q.vr.b[1]} & ~{q.hdr[12], q.hdr[13]}) == 16'h0))
		else $error("disabled digital line not zero");
	a_opt_gate: assert property ((O_PKT_READY && I_PKT_VALID && q.out_opt) |=>
		(q.st != ST_SOF)) else $error("rf frame with nonzero output option");
	a_bcast_bit: assert property ((O_PKT_READY && I_PKT_VALID && q.api_en && !q.out_opt) |=>
		(q.hdr[11][OPT_BCAST] == $past(I_PKT.bcast))) else $error("broadcast bit wrong");
	a_pay_limit: assert property ((q.st == ST_PAY) |-> (q.plen <= MAX_PAY && q.idx < q.plen))
		else $error("payload over limit");
	a_sof_delim: assert property ((q.st == ST_SOF && load) |=>
		(O_TX_DATA == DELIM ##1 (q.st != ST_SOF))) else $error("frame does not open with delimiter");
	a_csum_value: assert property ((q.st == ST_CSUM && load) |=>
		(8'(O_TX_DATA + $past(q.cks)) == CSUM_BASE && q.st != ST_CSUM)) else $error("checksum wrong");

	c_smp_frame: cover property (q.st == ST_CSUM && !q.kind && load);
	c_pkt_frame: cover property (q.st == ST_CSUM && q.kind && load);
	c_drop_tail: cover property (q.st == ST_DROP && q.rem == 11'h1 && fifo_vld);
	c_stall: cover property (O_TX_VALID && !I_TX_READY && q.st == ST_PAY);
endmodule

// ==== iosrf_pkg.sv ====
// package: constants and types of the io sample receive api framer
package iosrf_pkg;
	// frame bytes
	localparam logic [7:0]  DELIM       = 8'h7E;
	localparam logic [7:0]  TYPE_SMP    = 8'h8F;
	localparam logic [7:0]  TYPE_PKT    = 8'h90;
	localparam logic [7:0]  SMP_COUNT   = 8'h01;
	localparam logic [7:0]  RX_OPTS     = 8'h00;
	localparam logic [7:0]  RSV_HI      = 8'hFF;
	localparam logic [7:0]  RSV_LO      = 8'hFE;
	localparam logic [7:0]  CSUM_BASE   = 8'hFF;
	localparam int          OPT_BCAST   = 1;
	localparam logic [15:0] DMASK_USED  = 16'h1CFF;
	localparam logic [7:0]  AMASK_USED  = 8'h8F;
	localparam int          AMASK_VCC   = 7;
	// lengths
	localparam int          LEN_W       = 11;
	localparam logic [10:0] SMP_FIX_LEN = 11'h00F;
	localparam logic [10:0] PKT_FIX_LEN = 11'h00C;
	localparam logic [10:0] MAX_PAY     = 11'h570;
	localparam int          FIFO_DEPTH  = 32;
	localparam int          FIFO_W      = 8;
	// register map
	localparam logic [7:0]  REG_CTRL    = 8'h00;
	localparam logic [7:0]  REG_STAT    = 8'h04;
	localparam logic [7:0]  REG_SENT    = 8'h08;
	localparam logic [7:0]  REG_DROP    = 8'h0C;
	localparam int          CTRL_API    = 0;
	localparam int          CTRL_OPT    = 1;
	localparam logic        API_RST     = 1'b1;
	localparam logic [1:0]  RESP_OKAY   = 2'b00;
	localparam logic [1:0]  RESP_SLVERR = 2'b10;

	typedef enum logic [3:0] {ST_IDLE, ST_SOF, ST_LENH, ST_LENL, ST_FIX, ST_VAR, ST_PAY, ST_CSUM,
		ST_DROP} iosrf_st_t;

	typedef struct packed {
		logic [31:0]      ip;
		logic [7:0]       rssi;
		logic [15:0]      dmask;
		logic [15:0]      dsamp;
		logic [7:0]       amask;
		logic [3:0][15:0] aval;
		logic [15:0]      supply;
	} iosrf_smp_t;

	typedef struct packed {
		logic [31:0]      ip;
		logic             bcast;
		logic [LEN_W-1:0] len;
	} iosrf_pkt_t;

	typedef struct packed {
		logic [0:11][7:0] b;
		logic [3:0]       cnt;
	} iosrf_var_t;

	typedef struct packed {
		logic [7:0]  awaddr;
		logic        awvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        wvalid;
		logic        bready;
		logic [7:0]  araddr;
		logic        arvalid;
		logic        rready;
	} iosrf_axi_in_t;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} iosrf_axi_out_t;
endpackage

// ==== iosrf_fifo.sv ====
// file holds the payload byte fifo of the framer
`timescale 1ns/1ps
module iosrf_fifo #(
	parameter int W = 8,
	parameter int D = 32
) (
	input  wire logic         i_clk,
	input  wire logic         i_rst_n,
	input  wire logic         i_in_valid,
	input  wire logic [W-1:0] i_in_data,
	output logic              o_in_ready,
	output logic              o_out_valid,
	output logic [W-1:0]      o_out_data,
	input  wire logic         i_out_ready
);
	localparam int AW = $clog2(D);

	typedef struct packed {
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0]   cnt;
		logic          in_rdy;
	} iosrf_fifo_st_t;

	iosrf_fifo_st_t q;
	iosrf_fifo_st_t n;
	logic [W-1:0]   mem [0:D-1];
	logic           push;
	logic           pop;

	// handshakes on both sides
	assign push        = i_in_valid && q.in_rdy;
	assign pop         = o_out_valid && i_out_ready;
	assign o_in_ready  = q.in_rdy;
	assign o_out_valid = q.cnt != '0;
	assign o_out_data  = mem[q.rp];

	// pointer and level update
	always_comb
	begin
		n = q;
		if (push)
			n.wp = (q.wp == AW'(D - 1)) ? '0 : q.wp + 1'b1;
		if (pop)
			n.rp = (q.rp == AW'(D - 1)) ? '0 : q.rp + 1'b1;
		n.cnt    = q.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
		n.in_rdy = n.cnt != (AW + 1)'(D);
	end

	// state register
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			q <= '0;
		else
			q <= n;
	end

	// storage
	always_ff @(posedge i_clk)
	begin
		if (push)
			mem[q.wp] <= i_in_data;
	end

	a_fifo_bound: assert property (@(posedge i_clk) disable iff (!i_rst_n) q.cnt <= (AW + 1)'(D))
		else $error("fifo level above depth");
endmodule

// ==== iosrf_host_model.sv ====
// host side model: takes frame bytes with random stalls and checks framing
`timescale 1ns/1ps
module iosrf_host_model (
	input  wire logic       i_clk,
	input  wire logic       i_rst_n,
	input  wire logic [7:0] i_data,
	input  wire logic       i_valid,
	output logic            o_ready,
	output logic            o_got,
	output logic [7:0]      o_byte,
	output int              o_bad
);
	int          pos;
	logic [15:0] len;
	logic [7:0]  sum;

	// accept bytes, stall about one cycle in four, walk the frame layout
	always @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_ready <= 1'b0;
			o_got <= 1'b0;
			o_byte <= 8'h00;
			o_bad <= 0;
			pos <= 0;
		end
		else
		begin
			o_ready <= ($urandom % 4) != 0;
			o_got <= i_valid && o_ready;
			o_byte <= i_data;
			if (i_valid && o_ready)
			begin
				if (pos == 0)
				begin
					if (i_data != 8'h7E) o_bad <= o_bad + 1;
					else pos <= 1;
				end
				else if (pos == 1)
				begin
					len[15:8] <= i_data;
					pos <= 2;
				end
				else if (pos == 2)
				begin
					len[7:0] <= i_data;
					sum <= 8'h00;
					pos <= 3;
				end
				else if (pos < len + 3)
				begin
					sum <= sum + i_data;
					pos <= pos + 1;
				end
				else
				begin
					// bad checksum counts the frame as bad in o_bad
					if (8'hFF - sum != i_data) o_bad <= o_bad + 1;
					pos <= 0;
				end
			end
		end
	end
endmodule

// ==== tb_top.sv ====
// self-checking testbench of the io sample receive api framer
`timescale 1ns/1ps
module tb_top;
	import iosrf_pkg::*;
	logic           clk = 0;
	logic           nrst = 0;
	iosrf_axi_in_t  ai = '0;
	iosrf_axi_out_t axo;
	iosrf_smp_t     smp = '0;
	iosrf_pkt_t     pkt = '0;
	logic           smp_v = 0, pkt_v = 0, pay_v = 0;
	logic           smp_r, pkt_r, pay_r, tx_v, tx_r, got;
	logic [7:0]     pay_d = 0, tx_d, gbyte;
	logic [7:0]     exp_q[$], body[$];
	logic [31:0]    rd;
	logic [1:0]     rr;
	int             bad, num_errors = 0, n_tests = 0, n_smp = 0, n_pkt = 0;

	iosrf_framer iosrf_framer_inst (.I_MCLK(clk), .I_NRST(nrst), .I_AXI(ai), .O_AXI(axo),
		.I_SMP_VALID(smp_v), .I_SMP(smp), .O_SMP_READY(smp_r), .I_PKT_VALID(pkt_v), .I_PKT(pkt),
		.O_PKT_READY(pkt_r), .I_PAY_VALID(pay_v), .I_PAY_DATA(pay_d), .O_PAY_READY(pay_r),
		.O_TX_DATA(tx_d), .O_TX_VALID(tx_v), .I_TX_READY(tx_r));
	iosrf_host_model iosrf_host_model_inst (.i_clk(clk), .i_rst_n(nrst), .i_data(tx_d), .i_valid(tx_v),
		.o_ready(tx_r), .o_got(got), .o_byte(gbyte), .o_bad(bad));

	// 50 MHz clock
	initial forever #10 clk = ~clk;

	task chk(input logic [39:0] g, input logic [39:0] e);
		n_tests++;
		if (g !== e)
		begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task finish_test;
		$display("comparisons %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	// wrap the body in delimiter, length and checksum and note it as expected
	task emit;
		logic [7:0]  s;
		logic [15:0] l;
		s = 8'h00;
		l = 16'(body.size());
		foreach (body[i]) s += body[i];
		exp_q.push_back(DELIM);
		exp_q.push_back(l[15:8]);
		exp_q.push_back(l[7:0]);
		foreach (body[i]) exp_q.push_back(body[i]);
		exp_q.push_back(CSUM_BASE - s);
		body.delete();
	endtask

	task axi_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		ai.awaddr <= a; ai.awvalid <= 1; ai.wdata <= d; ai.wstrb <= 4'hF; ai.wvalid <= 1; ai.bready <= 1;
		do
		begin
			@(posedge clk);
			if (ai.awvalid && axo.awready) ai.awvalid <= 0;
			if (ai.wvalid && axo.wready) ai.wvalid <= 0;
		end while (!axo.bvalid);
		rr = axo.bresp;
		ai.bready <= 0;
	endtask

	task axi_rd(input logic [7:0] a);
		@(posedge clk);
		ai.araddr <= a; ai.arvalid <= 1; ai.rready <= 1;
		do
		begin
			@(posedge clk);
			if (ai.arvalid && axo.arready) ai.arvalid <= 0;
		end while (!axo.rvalid);
		rd = axo.rdata;
		rr = axo.rresp;
		ai.rready <= 0;
	endtask

	// random sample set; a frame is expected only when on is set
	task sample(input bit on);
		iosrf_smp_t  s;
		logic [15:0] dm;
		logic [7:0]  am;
		s = {$urandom, $urandom, $urandom, $urandom, $urandom};
		if ($urandom % 3 == 0) s.dmask = 16'h0000;
		if ($urandom % 3 == 0) s.amask = 8'h00;
		dm = s.dmask & DMASK_USED;
		am = s.amask & AMASK_USED;
		body = '{TYPE_SMP, 8'h00, 8'h00, 8'h00, 8'h00, s.ip[31:24], s.ip[23:16], s.ip[15:8], s.ip[7:0],
			s.rssi, RX_OPTS, SMP_COUNT, dm[15:8], dm[7:0], am};
		if (dm != 0) body = {body, s.dsamp[15:8] & dm[15:8], s.dsamp[7:0] & dm[7:0]};
		for (int i = 0; i < 4; i++) if (am[i]) body = {body, s.aval[i][15:8], s.aval[i][7:0]};
		if (am[AMASK_VCC]) body = {body, s.supply[15:8], s.supply[7:0]};
		if (on) emit();
		else body.delete();
		n_smp += on;
		@(posedge clk);
		smp <= s; smp_v <= 1;
		do @(posedge clk); while (!smp_r);
		smp_v <= 0;
	endtask

	// offer the packet header while n payload bytes stream into the buffer
	task packet(input int n, input bit on);
		logic [31:0] ip;
		logic        bc;
		logic [7:0]  pay[$];
		ip = $urandom;
		bc = $urandom;
		pay.delete();
		body = '{TYPE_PKT, 8'h00, 8'h00, 8'h00, 8'h00, ip[31:24], ip[23:16], ip[15:8], ip[7:0],
			RSV_HI, RSV_LO, {6'h00, bc, 1'b0}};
		for (int i = 0; i < n; i++) pay.push_back(8'($urandom));
		// bytes past the limit are drained, not framed
		foreach (pay[i]) if (i < int'(MAX_PAY)) body.push_back(pay[i]);
		if (on) emit();
		else body.delete();
		n_pkt += on;
		@(posedge clk);
		pkt <= '{ip: ip, bcast: bc, len: 11'(n)};
		pkt_v <= 1;
		fork
			begin
				do @(posedge clk); while (!pkt_r);
				pkt_v <= 0;
			end
			begin
				foreach (pay[i])
				begin
					pay_d <= pay[i];
					pay_v <= 1;
					do @(posedge clk); while (!pay_r);
				end
				pay_v <= 0;
			end
		join
	endtask

	task drain;
		while (exp_q.size() != 0) @(posedge clk);
		repeat (4) @(posedge clk);
	endtask

	// compare each byte the host takes with the oldest noted byte
	always @(posedge clk)
		if (got) chk(gbyte, exp_q.size() ? exp_q.pop_front() : 'x);

	// watchdog against a hang
	initial
	begin
		#1000000;
		num_errors++;
		finish_test();
	end

	// main sequence
	initial
	begin
		void'($urandom(32));
		repeat (3) @(posedge clk);
		nrst <= 1;
		repeat (4) @(posedge clk);
		axi_rd(REG_CTRL);
		chk({rr, rd}, {RESP_OKAY, 32'h1});
		axi_rd(8'h40);
		chk({rr, rd}, {RESP_SLVERR, 32'h0});
		axi_wr(8'h40, 32'h0);
		chk(rr, RESP_SLVERR);
		$display("test registers done");
		repeat (8) sample(1);
		drain();
		$display("test sample frames done");
		for (int i = 0; i < 4; i++) packet(i * 6, 1);
		packet(1400, 1);
		drain();
		$display("test packet frames done");
		@(posedge clk);
		for (int i = 0; i < FIFO_DEPTH; i++)
		begin
			pay_d <= 8'(i); pay_v <= 1;
			do @(posedge clk); while (!pay_r);
		end
		pay_v <= 0;
		repeat (2) @(posedge clk);
		@(negedge clk);
		chk(pay_r, 1'b0);
		body = '{TYPE_PKT, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, RSV_HI, RSV_LO, 8'h02};
		for (int i = 0; i < FIFO_DEPTH; i++) body.push_back(8'(i));
		emit();
		n_pkt++;
		@(posedge clk);
		pkt <= '{ip: 32'h0, bcast: 1'b1, len: 11'(FIFO_DEPTH)};
		pkt_v <= 1;
		do @(posedge clk); while (!pkt_r);
		pkt_v <= 0;
		drain();
		$display("test full buffer done");
		axi_wr(REG_CTRL, 32'h0);
		sample(0);
		packet(5, 0);
		axi_wr(REG_CTRL, 32'h3);
		axi_rd(REG_CTRL);
		chk({rr, rd}, {RESP_OKAY, 32'h0000_0003});
		packet(4, 0);
		sample(1);
		drain();
		axi_wr(REG_CTRL, 32'h1);
		packet(3, 1);
		drain();
		axi_rd(REG_DROP);
		chk(rd[15:0], 16'd3);
		axi_rd(REG_SENT);
		chk(rd, {16'(n_pkt), 16'(n_smp)});
		axi_rd(REG_STAT);
		chk({rr, rd}, {RESP_OKAY, 32'h0000_0002});
		chk(exp_q.size(), 0);
		chk(bad, 0);
		$display("test drop paths done");
		finish_test();
	end
endmodule
